// file: rtl/uepc_ep0_ctrl.sv
// Endpoint 0 peripheral control and status with transmit payload size.
// Assumes a packet engine reporting single-cycle events and a strobe register port.
`timescale 1ns/10ps
`default_nettype none
module uepc_ep0_ctrl
  import uepc_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire uepc_pkg::uepc_req_t req,
  output logic [15:0] rdata,
  input wire uepc_pkg::uepc_evt_t evt,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  input wire logic txByteReq,
  output logic [7:0] txByte,
  output logic [10:0] max_payload_bytes,
  output logic stallActive,
  output logic lastDataActive,
  output logic txLoaded,
  output logic fifoFlush,
  output logic [3:0] endpointSelect,
  output logic irq
);
  import uepc_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH_P);

  ////////////////////////////////////////////////////////////////////////////
  // Register decode.

  logic wrMaxp;
  logic wrCsr;
  logic wrIntStat;
  logic wrIntMask;
  logic wrIndex;
  logic wrFifo;
  logic rdFifo;
  assign wrMaxp = req.wr && req.addr == OFF_TX_SIZE;
  assign wrCsr = req.wr && req.addr == OFF_CSR0;
  assign wrIntStat = req.wr && req.addr == OFF_INTSTAT;
  assign wrIntMask = req.wr && req.addr == OFF_INTMASK;
  assign wrIndex = req.wr && req.addr == OFF_INDEX;
  assign wrFifo = req.wr && req.addr == OFF_FIFO;
  assign rdFifo = req.rd && req.addr == OFF_FIFO;

  logic cmdFlush;
  logic cmdSetupAck;
  logic cmdRxAck;
  logic cmdStall;
  logic cmdLastData;
  logic cmdStallSentWr;
  logic cmdTxLoad;
  assign cmdFlush = wrCsr && req.wdata[BIT_FLUSH];
  assign cmdSetupAck = wrCsr && req.wdata[BIT_SETUP_ACK];
  assign cmdRxAck = wrCsr && req.wdata[BIT_RX_ACK];
  assign cmdStall = wrCsr && req.wdata[BIT_STALL_REQ];
  assign cmdLastData = wrCsr && req.wdata[BIT_LAST_DATA];
  assign cmdStallSentWr = wrCsr;
  assign cmdTxLoad = wrCsr && req.wdata[BIT_TX_LOADED];

  ////////////////////////////////////////////////////////////////////////////
  // Maximum payload and index.

  logic [10:0] max_payload_bytes_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      max_payload_bytes_r <= MAXP_RST;
    end else if (wrMaxp) begin
      max_payload_bytes_r <= req.wdata[MAXP_W-1:0];
    end
  end
  assign max_payload_bytes = max_payload_bytes_r;

  logic [3:0] index_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      index_r <= INDEX_RST;
    end else if (wrIndex) begin
      index_r <= req.wdata[3:0];
    end
  end
  assign endpointSelect = index_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control and status flags.

  logic rxWaiting_r;
  logic txLoaded_r;
  logic stallSent_r;
  logic earlyEnd_r;
  logic stallReq_r;
  logic lastData_r;
  logic flushDo;
  logic earlyEvt;

  assign flushDo = cmdFlush && (txLoaded_r || rxWaiting_r);
  assign earlyEvt = evt.xferEnded && !lastData_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxWaiting_r <= 1'b0;
    end else if (evt.rxReceived) begin
      rxWaiting_r <= 1'b1;
    end else if (cmdRxAck || flushDo || earlyEvt) begin
      rxWaiting_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txLoaded_r <= 1'b0;
    end else if (evt.txSent || flushDo || earlyEvt) begin
      txLoaded_r <= 1'b0;
    end else if (cmdTxLoad) begin
      txLoaded_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stallSent_r <= 1'b0;
    end else if (evt.stallSent) begin
      stallSent_r <= 1'b1;
    end else if (cmdStallSentWr) begin
      stallSent_r <= req.wdata[BIT_STALL_SENT];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      earlyEnd_r <= 1'b0;
    end else if (earlyEvt) begin
      earlyEnd_r <= 1'b1;
    end else if (cmdSetupAck) begin
      earlyEnd_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stallReq_r <= 1'b0;
    end else if (evt.stallSent) begin
      stallReq_r <= 1'b0;
    end else if (cmdStall) begin
      stallReq_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lastData_r <= 1'b0;
    end else if (evt.txSent || evt.xferEnded || flushDo) begin
      lastData_r <= 1'b0;
    end else if (cmdLastData) begin
      lastData_r <= 1'b1;
    end
  end

  assign stallActive = stallReq_r;
  assign lastDataActive = lastData_r;
  assign txLoaded = txLoaded_r;
  assign fifoFlush = flushDo || earlyEvt;

  ////////////////////////////////////////////////////////////////////////////
  // Endpoint 0 FIFO with pointers.

  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic memWr;
  logic [7:0] memWData;
  logic [7:0] memRData;
  logic memRd;

  assign memWr = wrFifo || rxByteValid;
  assign memWData = rxByteValid ? rxByte : req.wdata[7:0];
  assign memRd = rdFifo || txByteReq;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
    end else if (fifoFlush) begin
      wrPtr_r <= '0;
    end else if (memWr) begin
      wrPtr_r <= wrPtr_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdPtr_r <= '0;
    end else if (fifoFlush) begin
      rdPtr_r <= '0;
    end else if (memRd) begin
      rdPtr_r <= rdPtr_r + 1'b1;
    end
  end

  uepc_fifo_mem #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH_P)
  ) uFifo (
    .clk_sys(clk_sys),
    .wrEn(memWr),
    .wrAddr(wrPtr_r),
    .wrData(memWData),
    .rdAddr(rdPtr_r),
    .rdData(memRData)
  );
  assign txByte = memRData;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  logic [INT_W-1:0] intEvt;
  logic [INT_W-1:0] intStat;
  logic [INT_W-1:0] intMask;
  logic [INT_W-1:0] intClr;
  always_comb begin
    intEvt = INT_RST;
    intEvt[INT_TX_DONE] = evt.txSent && txLoaded_r;
    intEvt[INT_RX_READY] = evt.rxReceived;
    intEvt[INT_EARLY_END] = earlyEvt;
    intEvt[INT_STALL_SENT] = evt.stallSent;
  end
  assign intClr = wrIntStat ? req.wdata[INT_W-1:0] : INT_RST;

  uepc_irq #(
    .W(INT_W)
  ) uIrq (
    .clk_sys(clk_sys),
    .rst(rst),
    .evt(intEvt),
    .clrBits(intClr),
    .maskWr(wrIntMask),
    .maskData(req.wdata[INT_W-1:0]),
    .status(intStat),
    .mask(intMask),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe.

  logic [15:0] rdata_nxt;
  logic rdFifo_r;
  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (req.addr)
      OFF_TX_SIZE: rdata_nxt = {5'h00, max_payload_bytes_r};
      OFF_CSR0: rdata_nxt = {11'h000, earlyEnd_r, 1'b0, stallSent_r,
                             txLoaded_r, rxWaiting_r};
      OFF_INTSTAT: rdata_nxt = {12'h000, intStat};
      OFF_INTMASK: rdata_nxt = {12'h000, intMask};
      OFF_INDEX: rdata_nxt = {12'h000, index_r};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  logic [15:0] rdata_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_r <= 16'h0000;
      rdFifo_r <= 1'b0;
    end else begin
      rdata_r <= req.rd ? rdata_nxt : 16'h0000;
      rdFifo_r <= rdFifo;
    end
  end
  assign rdata = rdFifo_r ? {8'h00, memRData} : rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  flush_clears_a: assert property (@(posedge clk_sys) disable iff (rst)
    flushDo && !evt.rxReceived && !cmdTxLoad |=> !txLoaded_r && !rxWaiting_r)
    else $error("flush did not clear packet flags");
  flush_ptr_a: assert property (@(posedge clk_sys) disable iff (rst)
    flushDo |=> wrPtr_r == '0 && rdPtr_r == '0)
    else $error("flush did not reset fifo pointers");
  flush_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmdFlush && !txLoaded_r && !rxWaiting_r && !earlyEvt |-> !fifoFlush)
    else $error("flush acted with no packet pending");
  setup_ack_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmdSetupAck && !earlyEvt |=> !earlyEnd_r)
    else $error("setup end not cleared by ack");
  rx_ack_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmdRxAck && !evt.rxReceived |=> !rxWaiting_r)
    else $error("receive waiting not cleared by ack");
  stall_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmdStall && !evt.stallSent |=> stallReq_r)
    else $error("stall request not taken");
  stall_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    evt.stallSent |=> !stallReq_r && stallSent_r)
    else $error("stall request not cleared after stall");
  early_end_a: assert property (@(posedge clk_sys) disable iff (rst)
    evt.xferEnded && !lastData_r |=> earlyEnd_r && wrPtr_r == '0 && intStat[INT_EARLY_END])
    else $error("early end not flagged");
  last_data_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
    evt.xferEnded || evt.txSent |=> !lastData_r)
    else $error("last data marker not cleared");
  rx_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    evt.rxReceived |=> rxWaiting_r && intStat[INT_RX_READY])
    else $error("receive not flagged");
  tx_done_a: assert property (@(posedge clk_sys) disable iff (rst)
    evt.txSent |=> !txLoaded_r && !lastData_r)
    else $error("loaded flag stayed after send");
  tx_irq_a: assert property (@(posedge clk_sys) disable iff (rst)
    evt.txSent && txLoaded_r |=> intStat[INT_TX_DONE])
    else $error("transmit done not flagged");
  csr_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    req.rd && req.addr == OFF_CSR0 |=> rdata[15:5] == 11'h000 && rdata[3] == 1'b0)
    else $error("command bits read nonzero");
  maxp_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
    wrMaxp ##1 !wrMaxp ##1 (req.rd && req.addr == OFF_TX_SIZE && !wrMaxp) |=>
      rdata[15:11] == 5'h00 && rdata[10:0] == $past(req.wdata[10:0], 3))
    else $error("max payload readback wrong");

  cov_flush_c: cover property (@(posedge clk_sys) disable iff (rst) flushDo);
  cov_early_c: cover property (@(posedge clk_sys) disable iff (rst) earlyEvt);
  cov_stall_c: cover property (@(posedge clk_sys) disable iff (rst) stallReq_r ##1 evt.stallSent);
  cov_irq_c: cover property (@(posedge clk_sys) disable iff (rst) irq);
endmodule
`default_nettype wire

// file: rtl/uepc_pkg.sv
// Package for the endpoint 0 peripheral control block.
// Assumes a single 25 MHz clock domain and a simple strobe register port.
package uepc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register offsets; byte addresses are not used on this port.
  localparam logic [3:0] OFF_TX_SIZE = 4'h0;
  localparam logic [3:0] OFF_CSR0 = 4'h1;
  localparam logic [3:0] OFF_INTSTAT = 4'h2;
  localparam logic [3:0] OFF_INTMASK = 4'h3;
  localparam logic [3:0] OFF_INDEX = 4'h4;
  localparam logic [3:0] OFF_FIFO = 4'h5;

  // Maximum payload field.
  localparam int MAXP_W = 11;
  localparam logic [10:0] MAXP_RST = 11'h000;

  // Control and status bit positions.
  localparam int BIT_FLUSH = 8;
  localparam int BIT_SETUP_ACK = 7;
  localparam int BIT_RX_ACK = 6;
  localparam int BIT_STALL_REQ = 5;
  localparam int BIT_EARLY_END = 4;
  localparam int BIT_LAST_DATA = 3;
  localparam int BIT_STALL_SENT = 2;
  localparam int BIT_TX_LOADED = 1;
  localparam int BIT_RX_WAITING = 0;

  // Interrupt status bit positions.
  localparam int INT_TX_DONE = 0;
  localparam int INT_RX_READY = 1;
  localparam int INT_EARLY_END = 2;
  localparam int INT_STALL_SENT = 3;
  localparam int INT_W = 4;
  localparam logic [3:0] INT_RST = 4'h0;

  localparam logic [3:0] INDEX_RST = 4'h0;
  localparam int FIFO_DEPTH = 64;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } uepc_req_t;

  // Events from the packet engine.
  typedef struct packed {
    logic txSent;
    logic rxReceived;
    logic stallSent;
    logic xferEnded;
  } uepc_evt_t;

  typedef enum logic [1:0] {
    UEPC_IDLE,
    UEPC_TX,
    UEPC_RX
  } uepc_state_t;

endpackage

// file: rtl/uepc_fifo_mem.sv
// Endpoint 0 packet buffer with a registered read port.
// Assumes one clock; pointers are kept by the caller.
`timescale 1ns/10ps
`default_nettype none
module uepc_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input wire logic clk_sys,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// file: rtl/uepc_irq.sv
// Sticky interrupt status with write-one-to-clear and a mask.
// Assumes events are single-cycle pulses on the system clock.
`timescale 1ns/10ps
`default_nettype none
module uepc_irq #(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] evt,
  input wire logic [W-1:0] clrBits,
  input wire logic maskWr,
  input wire logic [W-1:0] maskData,
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);
  // A set in the same cycle as a clear wins.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= (status & ~clrBits) | evt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask <= '0;
    end else if (maskWr) begin
      mask <= maskData;
    end
  end

  assign irq = |(status & mask);
endmodule
`default_nettype wire

// file: test/uepc_host_model.sv
// Behavioural packet engine on the bus side of endpoint 0.
// Assumes one clock; the bench starts one operation at a time with go.
`timescale 1ns/10ps
`default_nettype none
module uepc_host_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [1:0] op,
  input wire logic [3:0] gap,
  input wire logic stallActive,
  input wire logic txLoaded,
  output uepc_pkg::uepc_evt_t evt,
  output logic rxByteValid,
  output logic [7:0] rxByte,
  output logic txByteReq,
  output logic busy
);
  import uepc_pkg::*;
  logic [1:0] opR;
  logic [3:0] cntR;
  //////////////////////////////////////////////////////////////////////
  // Operations are 0 receive, 1 transmit, 2 stall, 3 end of transfer.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      opR <= 2'd0;
      cntR <= 4'h0;
      evt <= '0;
      rxByteValid <= 1'b0;
      rxByte <= 8'h00;
      txByteReq <= 1'b0;
    end else begin
      evt <= '0;
      rxByteValid <= 1'b0;
      txByteReq <= 1'b0;
      rxByte <= ~rxByte;
      if (go && !busy) begin
        busy <= 1'b1;
        opR <= op;
        cntR <= gap;
      end else if (busy && cntR != 4'h0) begin
        cntR <= cntR - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        case (opR)
          2'd0: begin
            rxByteValid <= 1'b1;
            rxByte <= 8'ha5;
            evt.rxReceived <= 1'b1;
          end
          2'd1: begin
            txByteReq <= txLoaded;
            evt.txSent <= txLoaded;
          end
          2'd2: evt.stallSent <= stallActive;
          default: evt.xferEnded <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: test/usb_ep0_peripheral_control_tb_top.sv
// Testbench for the endpoint 0 control block with a packet engine model.
// Assumes the register map and event timing of the design package.
`timescale 1ns/10ps
`default_nettype none
module usb_ep0_peripheral_control_tb_top;
  import uepc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst;
  uepc_req_t req;
  uepc_evt_t evt;
  logic [15:0] rdata;
  logic rxByteValid, txByteReq, hostGo, hostBusy;
  logic [7:0] rxByte, txByte;
  logic [1:0] hostOp;
  logic [3:0] hostGap, endpointSelect;
  logic [10:0] max_payload_bytes;
  logic stallActive, lastDataActive, txLoaded, fifoFlush, irq;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #20 clk_sys = ~clk_sys;
  uepc_ep0_ctrl dut (.clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata), .evt(evt),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .txByteReq(txByteReq), .txByte(txByte),
    .max_payload_bytes(max_payload_bytes), .stallActive(stallActive), .lastDataActive(lastDataActive),
    .txLoaded(txLoaded), .fifoFlush(fifoFlush), .endpointSelect(endpointSelect), .irq(irq));
  uepc_host_model host (.clk_sys(clk_sys), .rst(rst), .go(hostGo), .op(hostOp),
    .gap(hostGap), .stallActive(stallActive), .txLoaded(txLoaded), .evt(evt),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .txByteReq(txByteReq), .busy(hostBusy));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    chk(nm, rdata, e);
  endtask
  task automatic hop(input logic [1:0] o, input logic [3:0] g);
    int n;
    n = 0;
    @(posedge clk_sys);
    hostGo <= 1'b1;
    hostOp <= o;
    hostGap <= g;
    @(posedge clk_sys);
    hostGo <= 1'b0;
    #1;
    while (hostBusy !== 1'b0 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("host", {15'h0, hostBusy}, 16'h0);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    rst = 1'b1;
    req = '0;
    hostGo = 1'b0;
    hostOp = 2'd0;
    hostGap = 4'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OFF_TX_SIZE, 16'h0000, "maxp0");
    rd(OFF_CSR0, 16'h0000, "csr0");
    wr(OFF_TX_SIZE, 16'hffff);
    rd(OFF_TX_SIZE, 16'h07ff, "maxpf");
    wr(OFF_TX_SIZE, 16'h0400);
    rd(OFF_TX_SIZE, 16'h0400, "maxp1024");
    chk("max_payload_bytes", {5'h00, max_payload_bytes}, 16'h0400);
    rd(4'hf, 16'h0000, "unmapped");
    wr(OFF_INDEX, 16'h0003);
    chk("endpointSelect", {12'h000, endpointSelect}, 16'h0003);
    wr(OFF_INTMASK, 16'h000f);
    hop(2'd0, 4'h0);
    rd(OFF_CSR0, 16'h0001, "rxwait");
    rd(OFF_INTSTAT, 16'h0002, "intrx");
    chk("irqrx", {15'h0, irq}, 16'h0001);
    wr(OFF_CSR0, 16'h0040);
    rd(OFF_CSR0, 16'h0000, "rxack");
    wr(OFF_INTSTAT, 16'h0002);
    chk("irqclr", {15'h0, irq}, 16'h0000);
    wr(OFF_CSR0, 16'h000a);
    rd(OFF_CSR0, 16'h0002, "txload");
    chk("lastData", {15'h0, lastDataActive}, 16'h0001);
    hop(2'd1, 4'h3);
    rd(OFF_CSR0, 16'h0000, "txsent");
    rd(OFF_INTSTAT, 16'h0001, "inttx");
    chk("lastDataClr", {15'h0, lastDataActive}, 16'h0000);
    wr(OFF_INTSTAT, 16'h000f);
    wr(OFF_CSR0, 16'h0002);
    wr(OFF_CSR0, 16'h0100);
    rd(OFF_CSR0, 16'h0000, "flushtx");
    chk("txLoaded", {15'h0, txLoaded}, 16'h0000);
    hop(2'd0, 4'h1);
    wr(OFF_CSR0, 16'h0100);
    rd(OFF_CSR0, 16'h0000, "flushrx");
    wr(OFF_CSR0, 16'h0020);
    chk("stallReq", {15'h0, stallActive}, 16'h0001);
    rd(OFF_CSR0, 16'h0000, "stallrd");
    hop(2'd2, 4'h5);
    chk("stallDone", {15'h0, stallActive}, 16'h0000);
    rd(OFF_CSR0, 16'h0004, "stallsent");
    rd(OFF_INTSTAT, 16'h000a, "intstall");
    wr(OFF_FIFO, 16'h005a);
    wr(OFF_FIFO, 16'h00c3);
    chk("txByte", {8'h00, txByte}, 16'h005a);
    rd(OFF_FIFO, 16'h005a, "fifo0");
    wr(OFF_CSR0, 16'h0104);
    rd(OFF_CSR0, 16'h0004, "flushidle");
    rd(OFF_FIFO, 16'h00c3, "fifoKeep");
    wr(OFF_CSR0, 16'h0000);
    rd(OFF_CSR0, 16'h0000, "stallclr");
    wr(OFF_INTSTAT, 16'h000f);
    wr(OFF_CSR0, 16'h0002);
    hop(2'd3, 4'h0);
    rd(OFF_CSR0, 16'h0010, "earlyend");
    rd(OFF_INTSTAT, 16'h0004, "intend");
    chk("endFlush", {15'h0, txLoaded}, 16'h0000);
    wr(OFF_CSR0, 16'h0080);
    rd(OFF_CSR0, 16'h0000, "endack");
    wr(OFF_INTSTAT, 16'h000f);
    wr(OFF_INTMASK, 16'h0000);
    hop(2'd0, 4'h0);
    rd(OFF_INTSTAT, 16'h0002, "masked");
    chk("irqmask", {15'h0, irq}, 16'h0000);
    wr(OFF_INTMASK, 16'h0002);
    chk("irqunmask", {15'h0, irq}, 16'h0001);
    results();
  end
endmodule
`default_nettype wire
